// [src/wdg_downcounter.sv]
`timescale 1ns/1ps
// Operation
// - counter steps down once per 16384 oscillator cycles via a prescaler
// - lower six counter bits give 64 programmable timeout steps
// - active and counter rolling 40h to 3Fh starts a 30us reset pulse
// - counter runs whether active or not; inactive blocks every reset except the halt option's
// - disabled after reset; once the activate bit is set only a reset disables it
// - write with activate set and top bit clear resets at once
// - halt instruction while active resets instead of halting
// - control writes leave the prescaler phase untouched
// - base bounds: min (LSB+128)x64, max 16384 periods, per timebase
// - minimum adds linear or corrected increment around floor(MSB/4)
// - maximum uses same increments, first case up to floor(MSB/4)
// - options select halt reset and always-on hardware watchdog
// - hardware watchdog option forces active for resets and reads, ignores activate bit; watchdog_active shows only the activate bit
// - control resets to 7Fh, both fields read and write
// - halt with oscillator interrupt off and halt option resets
module wdg_downcounter
    import wdg_pkg::*;
#(
    parameter int PRESCALE_CYCLES = PRESCALE_DIV
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // core side
    input  wire logic              halt_exec,
    output logic                   halt_converted,
    // reset request and state
    output logic                   reset_out_n,
    output logic                   watchdog_active
);

    // ************************************************************
    // state
    // ************************************************************
    logic [PRESC_W-1:0]    presc_r;
    logic [PRESC_W-1:0]    presc_nxt;
    logic [CNT_W-1:0]      count_r;
    logic [CNT_W-1:0]      count_nxt;
    logic                  activate_r;
    logic                  activate_nxt;
    logic [CFG_USED_W-1:0] config_r;
    logic [1:0]            cause_r;
    logic [1:0]            cause_nxt;
    logic [PULSE_W-1:0]    pulse_cnt_r;
    logic [PULSE_W-1:0]    pulse_cnt_nxt;
    pulse_state_t          pstate_r;
    pulse_state_t          pstate_nxt;
    logic [DATA_W-1:0]     rdata_r;
    logic [DATA_W-1:0]     rdata_nxt;
    logic                  reset_out_n_r;
    logic                  halt_conv_r;
    logic                  halt_conv_nxt;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        ofs);
        hit = (a == ofs);
    endfunction

    wire logic wr_ctl = wr & hit(addr, OFS_CONTROL);
    wire logic wr_cfg = wr & hit(addr, OFS_CONFIG);

    // ************************************************************
    // configuration fields
    // ************************************************************
    wire logic [1:0] timebase_select =
        config_r[CFG_TB_HI:CFG_TB_LO];
    wire logic halt_reset_option           = config_r[CFG_HALT_RST_BIT];
    wire logic oscillator_interrupt_enable = config_r[CFG_OSC_IE_BIT];
    wire logic hw_watchdog                 = config_r[CFG_HW_WDG_BIT];

    // ************************************************************
    // prescaler
    // ************************************************************
    localparam logic [PRESC_W-1:0] PRESC_LAST =
        PRESC_W'(PRESCALE_CYCLES - 1);

    // free running; never reloaded by a write, so timeouts jitter
    // by up to one prescaler period
    wire logic presc_tick = (presc_r == PRESC_LAST);

    assign presc_nxt = presc_tick ? '0 : presc_r + PRESC_W'(1);

    // ************************************************************
    // activation
    // ************************************************************
    // activate only ever sets; a zero written later is dropped
    assign activate_nxt = activate_r |
        (wr_ctl & wdata[CTL_ACTIVATE_BIT]);

    // hardware option overrides the software activate bit
    wire logic active_now = activate_r | hw_watchdog;
    wire logic active_wr  = activate_nxt | hw_watchdog;

    // ************************************************************
    // downcounter
    // ************************************************************
    wire logic roll = presc_tick & (count_r == ROLL_FROM) & ~wr_ctl;

    // write load wins over a decrement in the same cycle; the count
    // keeps moving regardless of activation
    assign count_nxt = wr_ctl     ? wdata[CNT_W-1:0] :
                       presc_tick ? count_r - CNT_W'(1) :
                                    count_r;

    // ************************************************************
    // reset sources
    // ************************************************************
    wire logic soft_rst = wr_ctl & active_wr &
        ~wdata[CTL_TOP_BIT];
    wire logic tmo_rst  = roll & active_now;
    wire logic halt_act = halt_exec & active_now;
    wire logic halt_opt = halt_exec & ~oscillator_interrupt_enable &
        halt_reset_option;
    wire logic halt_rst = halt_act | halt_opt;
    wire logic any_rst  = soft_rst | tmo_rst | halt_rst;

    assign halt_conv_nxt = halt_rst;

    assign cause_nxt = ~any_rst       ? cause_r :
                       soft_rst       ? CAUSE_SOFTWARE :
                       tmo_rst        ? CAUSE_TIMEOUT :
                                        CAUSE_HALT;

    // ************************************************************
    // reset pulse
    // ************************************************************
    localparam logic [PULSE_W-1:0] PULSE_LAST =
        PULSE_W'(RESET_PULSE_CYC - 1);

    // requests during a pulse are merged into it, not queued
    always_comb begin
        pstate_nxt    = pstate_r;
        pulse_cnt_nxt = pulse_cnt_r;
        unique case (pstate_r)
            PS_IDLE: begin
                if (any_rst) begin
                    pstate_nxt    = PS_DRIVE;
                    pulse_cnt_nxt = '0;
                end
            end
            PS_DRIVE: begin
                if (pulse_cnt_r == PULSE_LAST) begin
                    pstate_nxt = PS_IDLE;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r + PULSE_W'(1);
                end
            end
        endcase
    end

    // ************************************************************
    // timeout bounds
    // ************************************************************
    logic [BOUND_W-1:0] tmin;
    logic [BOUND_W-1:0] tmax;

    wdg_timeout_bounds u_bounds (
        .timebase_select    (timebase_select),
        .timeout_step_count (count_r[STEP_W-1:0]),
        .tmin               (tmin),
        .tmax               (tmax)
    );

    // ************************************************************
    // read path
    // ************************************************************
    wire logic [DATA_W-1:0] ctl_view =
        {active_now, count_r};
    wire logic [DATA_W-1:0] cfg_view =
        {{(DATA_W-CFG_USED_W){1'b0}}, config_r};
    wire logic [DATA_W-1:0] sts_view =
        {4'h0, cause_r, pstate_r == PS_DRIVE, active_now};

    always_comb begin
        rdata_nxt = '0;
        if (rd) begin
            unique case (addr)
                OFS_CONTROL: rdata_nxt = ctl_view;
                OFS_CONFIG:  rdata_nxt = cfg_view;
                OFS_STATUS:  rdata_nxt = sts_view;
                OFS_TMIN_B0: rdata_nxt = tmin[7:0];
                OFS_TMIN_B1: rdata_nxt = tmin[15:8];
                OFS_TMIN_B2: rdata_nxt = tmin[23:16];
                OFS_TMAX_B0: rdata_nxt = tmax[7:0];
                OFS_TMAX_B1: rdata_nxt = tmax[15:8];
                OFS_TMAX_B2: rdata_nxt = tmax[23:16];
                default:     rdata_nxt = '0;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            presc_r    <= '0;
            count_r    <= CONTROL_RESET[CNT_W-1:0];
            activate_r <= CONTROL_RESET[CTL_ACTIVATE_BIT];
        end else begin
            presc_r    <= presc_nxt;
            count_r    <= count_nxt;
            activate_r <= activate_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            config_r <= CONFIG_RESET;
        end else if (wr_cfg) begin
            config_r <= wdata[CFG_USED_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pstate_r    <= PS_IDLE;
            pulse_cnt_r <= '0;
            cause_r     <= CAUSE_NONE;
            halt_conv_r <= 1'b0;
        end else begin
            pstate_r    <= pstate_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            cause_r     <= cause_nxt;
            halt_conv_r <= halt_conv_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r       <= '0;
            reset_out_n_r <= 1'b1;
        end else begin
            rdata_r       <= rdata_nxt;
            reset_out_n_r <= (pstate_nxt != PS_DRIVE);
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata           = rdata_r;
    assign reset_out_n     = reset_out_n_r;
    assign halt_converted  = halt_conv_r;
    assign watchdog_active = activate_r;

endmodule

// [src/wdg_pkg.sv]
package wdg_pkg;

    // ************************************************************
    // register bus geometry
    // ************************************************************
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 8;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0]  OFS_CONTROL       = 8'h2A;
    localparam logic [7:0]  OFS_CONFIG        = 8'h2B;
    localparam logic [7:0]  OFS_STATUS        = 8'h2C;
    localparam logic [7:0]  OFS_TMIN_B0       = 8'h2D;
    localparam logic [7:0]  OFS_TMIN_B1       = 8'h2E;
    localparam logic [7:0]  OFS_TMIN_B2       = 8'h2F;
    localparam logic [7:0]  OFS_TMAX_B0       = 8'h30;
    localparam logic [7:0]  OFS_TMAX_B1       = 8'h31;
    localparam logic [7:0]  OFS_TMAX_B2       = 8'h32;

    // ************************************************************
    // control register fields and reset value
    // ************************************************************
    localparam int          CTL_ACTIVATE_BIT  = 7;
    localparam int          CTL_TOP_BIT       = 6;
    localparam int          CNT_W             = 7;
    localparam int          STEP_W            = 6;
    localparam logic [7:0]  CONTROL_RESET     = 8'h7F;
    localparam logic [6:0]  ROLL_FROM         = 7'h40;

    // ************************************************************
    // config register fields and reset value
    // ************************************************************
    localparam int          CFG_TB_LO         = 0;
    localparam int          CFG_TB_HI         = 1;
    localparam int          CFG_HALT_RST_BIT  = 2;
    localparam int          CFG_OSC_IE_BIT    = 3;
    localparam int          CFG_HW_WDG_BIT    = 4;
    localparam int          CFG_USED_W        = 5;
    localparam logic [4:0]  CONFIG_RESET      = 5'h00;

    // ************************************************************
    // status register fields and reset cause codes
    // ************************************************************
    localparam int          STS_ACTIVE_BIT    = 0;
    localparam int          STS_PULSE_BIT     = 1;
    localparam int          STS_CAUSE_LO      = 2;
    localparam logic [1:0]  CAUSE_NONE        = 2'h0;
    localparam logic [1:0]  CAUSE_TIMEOUT     = 2'h1;
    localparam logic [1:0]  CAUSE_SOFTWARE    = 2'h2;
    localparam logic [1:0]  CAUSE_HALT        = 2'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_PERIOD_NS     = 50;
    localparam int          PRESCALE_DIV      = 16384;
    localparam int          PRESC_W           = 14;
    localparam int          RESET_PULSE_NS    = 30000;
    localparam int          RESET_PULSE_CYC   =
        (RESET_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
        RESET_PULSE_NS / CLK_PERIOD_NS;
    localparam int          PULSE_W           = 10;

    // ************************************************************
    // timeout bound arithmetic
    // ************************************************************
    localparam int          BOUND_W           = 24;
    localparam int          MIN_BASE_ADD      = 128;
    localparam int          STEP_MUL          = 64;
    localparam int          CORR_ADD          = 192;
    localparam int          QUOT_MUL          = 4;
    localparam logic [7:0]  TB0_MSB           = 8'h04;
    localparam logic [7:0]  TB0_LSB           = 8'h3B;
    localparam logic [7:0]  TB1_MSB           = 8'h08;
    localparam logic [7:0]  TB1_LSB           = 8'h35;
    localparam logic [7:0]  TB2_MSB           = 8'h14;
    localparam logic [7:0]  TB2_LSB           = 8'h23;
    localparam logic [7:0]  TB3_MSB           = 8'h31;
    localparam logic [7:0]  TB3_LSB           = 8'h36;

    typedef enum logic {
        PS_IDLE  = 1'b0,
        PS_DRIVE = 1'b1
    } pulse_state_t;

endpackage

// [src/wdg_timeout_bounds.sv]
`timescale 1ns/1ps
module wdg_timeout_bounds
    import wdg_pkg::*;
(
    // selection
    input  wire logic [1:0]         timebase_select,
    input  wire logic [STEP_W-1:0]  timeout_step_count,
    // bounds in oscillator periods
    output logic      [BOUND_W-1:0] tmin,
    output logic      [BOUND_W-1:0] tmax
);

    // ************************************************************
    // timebase table
    // ************************************************************
    function automatic logic [15:0] tb_entry(input logic [1:0] tb);
        unique case (tb)
            2'h0: tb_entry = {TB0_MSB, TB0_LSB};
            2'h1: tb_entry = {TB1_MSB, TB1_LSB};
            2'h2: tb_entry = {TB2_MSB, TB2_LSB};
            2'h3: tb_entry = {TB3_MSB, TB3_LSB};
        endcase
    endfunction

    wire logic [15:0]        table_word = tb_entry(timebase_select);
    wire logic [BOUND_W-1:0] msb_v = BOUND_W'(table_word[15:8]);
    wire logic [BOUND_W-1:0] lsb_v = BOUND_W'(table_word[7:0]);
    wire logic [BOUND_W-1:0] cnt_v = BOUND_W'(timeout_step_count);

    // all divisions truncate toward zero
    wire logic [BOUND_W-1:0] thresh = msb_v / BOUND_W'(QUOT_MUL);
    wire logic [BOUND_W-1:0] quot   =
        (cnt_v * BOUND_W'(QUOT_MUL)) / msb_v;

    wire logic [BOUND_W-1:0] min0   =
        (lsb_v + BOUND_W'(MIN_BASE_ADD)) * BOUND_W'(STEP_MUL);
    wire logic [BOUND_W-1:0] max0   = BOUND_W'(PRESCALE_DIV);

    wire logic [BOUND_W-1:0] lin    = BOUND_W'(PRESCALE_DIV) * cnt_v;
    wire logic [BOUND_W-1:0] corr   =
        BOUND_W'(PRESCALE_DIV) * (cnt_v - quot) +
        (BOUND_W'(CORR_ADD) + lsb_v) * BOUND_W'(STEP_MUL) * quot;

    assign tmin = min0 + ((cnt_v < thresh) ? lin : corr);
    assign tmax = max0 + ((cnt_v <= thresh) ? lin : corr);

endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    import wdg_pkg::*;
    // short prescaler keeps the run brief; timeout waits derive from it, bound figures still use 16384
    localparam int P = 32;
    logic        clk;
    logic        rstn;
    logic        wr;
    logic        rd;
    logic        halt_exec;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  v;
    logic [47:0] got;
    logic        halt_converted;
    logic        reset_out_n;
    logic        watchdog_active;
    int          n_errors = 0;
    int          n_tests = 0;
    int          msb_t[4] = '{4, 8, 20, 49};
    int          lsb_t[4] = '{59, 53, 35, 54};
    int          cnt_t[4] = '{63, 2, 5, 16};

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    wdg_downcounter #(.PRESCALE_CYCLES(P)) u_dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .halt_exec(halt_exec),
        .halt_converted(halt_converted), .reset_out_n(reset_out_n),
        .watchdog_active(watchdog_active));

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [23:0] g, input logic [23:0] e,
                       input string m);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic do_halt;
        @(posedge clk);
        halt_exec <= 1'b1;
        @(posedge clk);
        halt_exec <= 1'b0;
        #1;
    endtask

    // waits up to lim cycles for the pulse, then times its length
    task automatic pulse(input int lim, input logic conv);
        int k;
        k = 0;
        while (reset_out_n !== 1'b0 && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(halt_converted, conv, "cause flag");
        k = 0;
        while (reset_out_n === 1'b0 && k < RESET_PULSE_CYC + 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(24'(k), 24'(RESET_PULSE_CYC), "pulse length");
        if (k != RESET_PULSE_CYC) complete_run();
    endtask

    function automatic logic [23:0] exp_b(input int m, input int l,
                                          input int c, input bit mx);
        int q;
        int inc;
        q = 4 * c / m;
        inc = 16384 * (c - q) + (192 + l) * 64 * q;
        if (mx) return 24'(16384 + ((c <= m / 4) ? 16384 * c : inc));
        return 24'((l + 128) * 64 + ((c < m / 4) ? 16384 * c : inc));
    endfunction

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        halt_exec = 1'b0;
        do_reset();
        rd_reg(OFS_CONTROL, v);
        chk(v, 8'h7F, "control reset");
        chk(watchdog_active, 1'b0, "active after reset");
        wr_reg(8'h00, 8'h5A);
        rd_reg(8'h00, v);
        chk(v, 8'h00, "unmapped");
        // prescaler phase runs from reset release, so the first tick
        // lands between these two accesses, as no write restarts it
        wr_reg(OFS_CONTROL, 8'h7A);
        repeat (P - 2) @(posedge clk);
        rd_reg(OFS_CONTROL, v);
        chk(v, 8'h79, "free count");
        $display("test reset_and_count done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_CONFIG, i[7:0]);
            // retry if a tick moved the count between byte reads
            for (int t = 0; t < 4; t++) begin
                wr_reg(OFS_CONTROL, 8'h40 | cnt_t[i][7:0]);
                for (int b = 0; b < 6; b++) begin
                    rd_reg(OFS_TMIN_B0 + b[7:0], v);
                    got[b*8 +: 8] = v;
                end
                rd_reg(OFS_CONTROL, v);
                if (v === (8'h40 | cnt_t[i][7:0])) break;
            end
            chk(got[23:0], exp_b(msb_t[i], lsb_t[i], cnt_t[i], 0),
                "min");
            chk(got[47:24], exp_b(msb_t[i], lsb_t[i], cnt_t[i], 1),
                "max");
        end
        $display("test bounds done");
        wr_reg(OFS_CONFIG, 8'h0C);
        do_halt();
        #150;
        chk(reset_out_n, 1'b1, "halt with osc ie");
        wr_reg(OFS_CONFIG, 8'h04);
        do_halt();
        pulse(0, 1'b1);
        $display("test halt_option done");
        do_reset();
        wr_reg(OFS_CONTROL, 8'h80);
        pulse(0, 1'b0);
        wr_reg(OFS_CONTROL, 8'h45);
        rd_reg(OFS_CONTROL, v);
        chk(v[7:1], 7'h62, "keep active, load count");
        wr_reg(OFS_CONTROL, 8'hC0);
        pulse(P + 1, 1'b0);
        chk(watchdog_active, 1'b1, "still active");
        rd_reg(OFS_STATUS, v);
        chk(v, {4'h0, CAUSE_TIMEOUT, 2'h1}, "timeout cause");
        do_halt();
        pulse(0, 1'b1);
        rd_reg(OFS_STATUS, v);
        chk(v, {4'h0, CAUSE_HALT, 2'h1}, "halt cause");
        wr_reg(OFS_CONTROL, 8'h3F);
        pulse(0, 1'b0);
        $display("test active_resets done");
        do_reset();
        chk(watchdog_active, 1'b0, "cleared by reset");
        wr_reg(OFS_CONFIG, 8'h10);
        rd_reg(OFS_CONFIG, v);
        chk(v, 8'h10, "config readback");
        rd_reg(OFS_CONTROL, v);
        chk(v[7], 1'b1, "hw option active");
        wr_reg(OFS_CONTROL, 8'h40);
        pulse(P + 1, 1'b0);
        $display("test hw_option done");
        complete_run();
    end
endmodule

// [verification/wdg_properties.sv]
`timescale 1ns/1ps
module wdg_properties
    import wdg_pkg::*;
#(
    parameter int PRESCALE_CYCLES = PRESCALE_DIV
)
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    // core and reset side
    input wire logic              halt_exec,
    input wire logic              halt_converted,
    input wire logic              reset_out_n,
    input wire logic              watchdog_active
);
    // ****************************************
    // helpers
    // ****************************************
    // reset output is registered one cycle after the tick, hence one spare cycle
    localparam int TMO       = PRESCALE_CYCLES + 1;
    localparam int PULSE_CYC = RESET_PULSE_CYC;
    logic [10:0] lo_cnt_r;
    wire         ctl_wr;
    assign ctl_wr = wr && addr == OFS_CONTROL;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lo_cnt_r <= 11'h000;
        end else if (reset_out_n) begin
            lo_cnt_r <= 11'h000;
        end else begin
            lo_cnt_r <= lo_cnt_r + 11'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence sw_req;
        ctl_wr && !wdata[6] && (wdata[7] || watchdog_active) && reset_out_n;
    endsequence
    sequence arm_40;
        ctl_wr && wdata == 8'hC0 && reset_out_n;
    endsequence

    // ****************************************
    // checks
    // ****************************************
    a_soft_reset: assert property (sw_req |=> !reset_out_n)
        else $error("software reset missing");
    a_timeout_bound: assert property (arm_40 |-> ##[1:TMO] !reset_out_n)
        else $error("timeout reset late");
    a_pulse_len: assert property ($rose(reset_out_n)
        |-> lo_cnt_r == PULSE_CYC)
        else $error("reset pulse length wrong");
    a_halt_reset: assert property (halt_exec && watchdog_active && reset_out_n
        && !wr |=> !reset_out_n && halt_converted)
        else $error("halt not converted");
    a_conv_cause: assert property (halt_converted |-> $past(halt_exec))
        else $error("conversion without halt");
    a_active_hold: assert property (watchdog_active |=> watchdog_active)
        else $error("activate bit cleared");
    a_active_rise: assert property ($rose(watchdog_active)
        |-> $past(ctl_wr && wdata[7]))
        else $error("activate set without write");
    a_rd_ctl_act: assert property (rd && addr == OFS_CONTROL && watchdog_active
        |=> rdata[7])
        else $error("control bit7 lost");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside slot");
    a_unmapped_rd: assert property (rd && (addr < OFS_CONTROL
        || addr > OFS_TMAX_B2) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind wdg_downcounter wdg_properties
    #(.PRESCALE_CYCLES(PRESCALE_CYCLES)) u_props (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .halt_exec(halt_exec), .halt_converted(halt_converted),
    .reset_out_n(reset_out_n), .watchdog_active(watchdog_active));
